//--- boot_shadow_memory_map.v
// memory map decoder and shadow configuration register
// assumes core strobes are synchronous to core_clk; outputs registered
//
// Contract
// - shadow clear: boot rom at code 0000-27FF and alias 8000-A7FF.
// - shadow clear: program ram in external data 0000-3FFF, read/write.
// - external data F800-FFFF always decodes buffers, registers, i/o.
// - shadow set: rom only at code 8000h, ram code from 0000h.
// - shadow set: ram is read-only code, every write blocked.
// - shadow bit resets to 0 on power-up/watchdog; core can only set.
// - shadow clear: instruction fetches come from boot rom.
// - shadow set: fetches at 0000-3FFF come from program ram, 8000-A7FF from boot rom.
// - register bits 4..1 reserved, read 0000b, writes ignored.
// - bits 6..5 read-only, fixed 10b meaning 16K, no reset effect.
// - size code 00=4K, 01=8K, 10=16K, 11=32K.
// - bit 7 read-only fixed 1, code space is ram.
// - configuration register decoded at data address FF90h.
// - 256-byte scratch ram is core-internal, outside these maps.
`include "memmap_consts.vh"
`default_nettype none
module boot_shadow_memory_map (
	input wire core_clk,
	input wire reset,
	input wire wdt_reset,
	input wire code_rd,
	input wire [15:0] code_addr,
	input wire data_rd,
	input wire data_wr,
	input wire [15:0] data_addr,
	input wire [7:0] data_wdata,
	output reg [1:0] code_sel_r,
	output reg [13:0] code_offset_r,
	output reg [1:0] data_sel_r,
	output reg [13:0] data_offset_r,
	output reg ram_we_r,
	output reg io_sel_r,
	output reg [7:0] cfg_rdata_r,
	output reg cfg_rvalid_r,
	output reg shadow_enable_r
);
	wire c_rom_lo;
	wire c_rom_hi;
	wire c_ram;
	wire d_ram;
	wire d_io;
	wire cfg_hit;
	reg [1:0] code_sel_nxt;
	reg [13:0] code_offset_nxt;
	reg [1:0] data_sel_nxt;
	reg [13:0] data_offset_nxt;
	reg ram_we_nxt;
	wire [7:0] cfg_value;

	range_hit #(.LO(`ROM_LO_BASE), .HI(`ROM_LO_LAST)) u_rlo (
		.addr(code_addr),
		.hit(c_rom_lo)
	);
	range_hit #(.LO(`ROM_HI_BASE), .HI(`ROM_HI_LAST)) u_rhi (
		.addr(code_addr),
		.hit(c_rom_hi)
	);
	range_hit #(.LO(`RAM_BASE), .HI(`RAM_LAST)) u_cram (
		.addr(code_addr),
		.hit(c_ram)
	);
	range_hit #(.LO(`RAM_BASE), .HI(`RAM_LAST)) u_dram (
		.addr(data_addr),
		.hit(d_ram)
	);
	range_hit #(.LO(`IO_BASE), .HI(`IO_LAST)) u_dio (
		.addr(data_addr),
		.hit(d_io)
	);

	assign cfg_hit = (data_addr == `SHADOW_CFG_ADDR);
	// scratch ram 00..SCRATCH_LAST lives inside the core, not decoded here

	// fixed fields and reserved bits
	assign cfg_value = {`CODE_IS_RAM, `CODE_SIZE_16K, `RSVD_READ,
		shadow_enable_r};

	// code space decode
	always @*
	begin
		code_sel_nxt = `SEL_NONE;
		code_offset_nxt = 14'h0000;
		if (!shadow_enable_r)
		begin
			if (c_rom_lo)
			begin
				code_sel_nxt = `SEL_ROM;
				code_offset_nxt = code_addr[13:0];
			end
			else if (c_rom_hi)
			begin
				code_sel_nxt = `SEL_ROM;
				code_offset_nxt = code_addr[13:0];
			end
		end
		else
		begin
			if (c_ram)
			begin
				code_sel_nxt = `SEL_RAM;
				code_offset_nxt = code_addr[13:0];
			end
			else if (c_rom_hi)
			begin
				code_sel_nxt = `SEL_ROM;
				code_offset_nxt = code_addr[13:0];
			end
		end
		if (!code_rd)
		begin
			code_sel_nxt = `SEL_NONE;
			code_offset_nxt = 14'h0000;
		end
	end

	// external data space decode
	always @*
	begin
		data_sel_nxt = `SEL_NONE;
		data_offset_nxt = 14'h0000;
		ram_we_nxt = 1'b0;
		if (d_io)
		begin
			data_sel_nxt = `SEL_IO;
			data_offset_nxt = {3'h0, data_addr[10:0]};
		end
		else if (d_ram && !shadow_enable_r)
		begin
			data_sel_nxt = `SEL_RAM;
			data_offset_nxt = data_addr[13:0];
			ram_we_nxt = data_wr;
		end
		if (!(data_rd || data_wr))
		begin
			data_sel_nxt = `SEL_NONE;
			data_offset_nxt = 14'h0000;
		end
	end

	always @(posedge core_clk or posedge reset)
	begin
		if (reset)
		begin
			code_sel_r <= `SEL_NONE;
			code_offset_r <= 14'h0000;
			data_sel_r <= `SEL_NONE;
			data_offset_r <= 14'h0000;
			ram_we_r <= 1'b0;
			io_sel_r <= 1'b0;
			cfg_rdata_r <= 8'h00;
			cfg_rvalid_r <= 1'b0;
		end
		else
		begin
			code_sel_r <= code_sel_nxt;
			code_offset_r <= code_offset_nxt;
			data_sel_r <= data_sel_nxt;
			data_offset_r <= data_offset_nxt;
			ram_we_r <= ram_we_nxt && !shadow_enable_r;
			io_sel_r <= (data_rd || data_wr) && d_io && !cfg_hit;
			cfg_rvalid_r <= data_rd && cfg_hit;
			cfg_rdata_r <= (data_rd && cfg_hit) ? cfg_value : 8'h00;
		end
	end

	// shadow bit: only set by a write, cleared only by resets
	always @(posedge core_clk or posedge reset)
	begin
		if (reset)
			shadow_enable_r <= 1'b0;
		else if (wdt_reset)
			shadow_enable_r <= 1'b0;
		else if (data_wr && cfg_hit && data_wdata[`SHADOW_BIT])
			shadow_enable_r <= 1'b1;
	end
	// connect sequencing after shadow set is firmware duty
endmodule // boot_shadow_memory_map
`default_nettype wire

//--- memmap_consts.vh
// memory map constants for the boot/shadow address decoder
// assumes 16-bit code and data addresses from an 8-bit core
`ifndef MEMMAP_CONSTS_VH
`define MEMMAP_CONSTS_VH
`define ROM_LO_BASE 16'h0000
`define ROM_LO_LAST 16'h27FF
`define ROM_HI_BASE 16'h8000
`define ROM_HI_LAST 16'hA7FF
`define RAM_BASE 16'h0000
`define RAM_LAST 16'h3FFF
`define IO_BASE 16'hF800
`define IO_LAST 16'hFFFF
`define SHADOW_CFG_ADDR 16'hFF90
`define SCRATCH_LAST 8'hFF
`define SHADOW_BIT 0
`define CODE_SIZE_16K 2'h2
`define CODE_IS_RAM 1'h1
`define RSVD_READ 4'h0
`define SEL_NONE 2'h0
`define SEL_ROM 2'h1
`define SEL_RAM 2'h2
`define SEL_IO 2'h3
`endif

//--- range_hit.v
// address window compare: high when addr lies in [lo, hi]
// assumes combinational use inside the decoder
`default_nettype none
module range_hit #(
	parameter [15:0] LO = 16'h0000,
	parameter [15:0] HI = 16'hFFFF
) (
	input wire [15:0] addr,
	output wire hit
);
	assign hit = (addr >= LO) && (addr <= HI);
endmodule // range_hit
`default_nettype wire

//--- shadow_map_monitor.sv
// decode checker, bound onto the decoder's ports
`default_nettype none
module shadow_map_monitor(input wire logic core_clk,reset,wdt_reset,code_rd,
data_rd,data_wr,ram_we_r,cfg_rvalid_r,shadow_enable_r,
input wire logic [15:0] code_addr,data_addr,input wire logic [7:0] cfg_rdata_r,
input wire logic [1:0] code_sel_r,data_sel_r);
timeunit 1ns;
timeprecision 1ns;
wire s=shadow_enable_r;
wire [15:0] ca=code_addr,da=data_addr;
default clocking @(posedge core_clk); endclocking
default disable iff (reset);
property p_lo; code_rd&&!s&&ca<16'h2800|=>code_sel_r==2'h1; endproperty
a_lo: assert property(p_lo) else $error("lo");
property p_hi; code_rd&&ca>=16'h8000&&ca<16'hA800|=>code_sel_r==2'h1;
endproperty
a_hi: assert property(p_hi) else $error("hi");
property p_rc; code_rd&&s&&ca<16'h4000|=>code_sel_r==2'h2; endproperty
a_rc: assert property(p_rc) else $error("rc");
property p_dw; data_wr&&!s&&da<16'h4000|=>data_sel_r==2'h2&&ram_we_r;
endproperty
a_dw: assert property(p_dw) else $error("dw");
property p_wb; s|=>!ram_we_r; endproperty
a_wb: assert property(p_wb) else $error("wb");
property p_io; data_rd&&da>=16'hF800&&da!=16'hFF90|=>data_sel_r==2'h3;
endproperty
a_io: assert property(p_io) else $error("io");
property p_cf; data_rd&&da==16'hFF90|=>cfg_rvalid_r&&
cfg_rdata_r=={7'h60,$past(s)}; endproperty
a_cf: assert property(p_cf) else $error("cf");
property p_st; s&&!wdt_reset|=>s; endproperty
a_st: assert property(p_st) else $error("st");
property p_wd; wdt_reset|=>!s; endproperty
a_wd: assert property(p_wd) else $error("wd");
property p_gap; code_rd&&s&&ca>=16'h4000&&ca<16'h8000|=>code_sel_r==2'h0;
endproperty
a_gap: assert property(p_gap) else $error("gap");
endmodule // shadow_map_monitor
bind boot_shadow_memory_map shadow_map_monitor mon_u(.*);
`default_nettype wire

//--- core_model.sv
// core issuing one access per call; decoder answers one edge later
`default_nettype none
module core_model(input wire logic core_clk,output logic code_rd,data_rd,
data_wr,output logic [15:0] code_addr,data_addr,output logic [7:0] data_wdata);
timeunit 1ns;
timeprecision 1ns;
initial {code_rd,data_rd,data_wr,code_addr,data_addr,data_wdata}=43'h0;
task automatic acc(input logic [2:0] k,logic [15:0] a,logic [7:0] d);
	@(posedge core_clk);
	{code_rd,data_rd,data_wr,code_addr,data_addr,data_wdata}<={k,a,a,d};
	@(posedge core_clk);
	{code_rd,data_rd,data_wr,data_wdata}<={3'h0,~d};
	#1;
endtask
endmodule // core_model
`default_nettype wire

//--- boot_shadow_memory_map_tb_top.sv
// bench for the shadow map decoder; core_model drives the core side
`default_nettype none
module boot_shadow_memory_map_tb_top;
timeunit 1ns;
timeprecision 1ns;
localparam addrs=128'hA800A7FF800040003FFF280027FF0000;
logic core_clk=0,reset=1,wdt_reset=0,code_rd,data_rd,data_wr,ram_we_r;
logic io_sel_r,cfg_rvalid_r,shadow_enable_r;
logic [15:0] code_addr,data_addr;
logic [7:0] data_wdata,cfg_rdata_r;
logic [1:0] code_sel_r,data_sel_r;
logic [13:0] code_offset_r,data_offset_r;
int errors=0,tests_run=0;
always #50 core_clk=~core_clk;
core_model core_u(.*);
boot_shadow_memory_map dut_u(.*);
task automatic chk(input logic [31:0] g,e);
	tests_run++;
	errors+=int'(g!==e);
	if (g!==e)
		$display("CHECK FAILED %0t got %h exp %h",$time,g,e);
endtask
task automatic codes(input logic [15:0] e);
	for (int i=0;i<8;i++)
	begin
		core_u.acc(3'h4,addrs[16*i+:16],8'h0);
		chk(code_sel_r,e[2*i+:2]);
		chk(code_offset_r,(e[2*i+:2]!=2'h0)?addrs[16*i+:14]:14'h0);
	end
endtask
task automatic conclude;
	$display("errors %0d tests_run %0d",errors,tests_run);
	if (errors==0&&tests_run>0)
		$display("SIMULATION PASSED");
	else
		$display("SIMULATION FAILED");
	$finish;
endtask
initial
begin
	#100000 errors++;
	conclude;
end
initial
begin
	repeat (5) @(posedge core_clk);
	reset<=1'h0;
	codes(16'h1405);
	core_u.acc(3'h1,16'h3FFF,8'h5A);
	chk({data_sel_r,ram_we_r,data_offset_r},{3'h5,14'h3FFF});
	core_u.acc(3'h2,16'hF800,8'h0);
	chk({data_sel_r,io_sel_r,data_offset_r},{3'h7,14'h0000});
	core_u.acc(3'h1,16'hFF90,8'hFE);
	core_u.acc(3'h2,16'hFF90,8'h0);
	chk({cfg_rvalid_r,cfg_rdata_r},9'h1C0);
	core_u.acc(3'h1,16'hFF90,8'h1);
	core_u.acc(3'h1,16'hFF90,8'h0);
	core_u.acc(3'h2,16'hFF90,8'h0);
	chk({cfg_rvalid_r,cfg_rdata_r},9'h1C1);
	codes(16'h14AA);
	core_u.acc(3'h1,16'h0,8'hA5);
	chk({data_sel_r,ram_we_r},3'h0);
	@(posedge core_clk) wdt_reset<=1'h1;
	@(posedge core_clk) wdt_reset<=1'h0;
	#1 chk(shadow_enable_r,1'h0);
	core_u.acc(3'h1,16'hFF90,8'h1);
	chk(shadow_enable_r,1'h1);
	@(posedge core_clk) reset<=1'h1;
	@(posedge core_clk) reset<=1'h0;
	#1 chk(shadow_enable_r,1'h0);
	conclude;
end
endmodule // boot_shadow_memory_map_tb_top
`default_nettype wire
